// ===== common/dtlb_exc_pkg.sv
// Constants, types and register map of the data translation fault unit
package dtlb_exc_pkg;
  // Buffer geometry
  localparam int ENTRIES = 64;
  localparam int IDX_W   = 6;

  // Event codes
  localparam logic [31:0] CODE_MULTI   = 32'h0000_0140;
  localparam logic [31:0] CODE_MISS_RD = 32'h0000_0040;
  localparam logic [31:0] CODE_MISS_WR = 32'h0000_0060;
  localparam logic [31:0] CODE_PROT_RD = 32'h0000_00a0;
  localparam logic [31:0] CODE_PROT_WR = 32'h0000_00c0;
  localparam logic [31:0] CODE_IPW     = 32'h0000_0080;

  // Vectors and offsets
  localparam logic [31:0] RESET_VECTOR = 32'ha000_0000;
  localparam logic [31:0] OFF_MISS     = 32'h0000_0400;
  localparam logic [31:0] OFF_PROT     = 32'h0000_0100;

  // State word bit positions and reset value
  localparam int          PRIV_MODE_POS = 30;
  localparam int          BANK_SEL_POS  = 29;
  localparam int          EXC_BLOCK_POS = 28;
  localparam logic [31:0] STATE_RESET   = 32'h7000_00f0;

  // Control register fields
  localparam int RCNT_LSB = 10;
  localparam int RBND_LSB = 18;

  // Page entry field positions
  localparam int PAGE_NUM_LSB  = 10;
  localparam int PHYS_PAGE_LSB = 10;
  localparam int PHYS_PAGE_MSB = 28;
  localparam int V_BIT         = 8;
  localparam int SZ1_BIT       = 7;
  localparam int RIGHTS_LSB    = 5;
  localparam int SZ0_BIT       = 4;
  localparam int D_BIT         = 2;
  localparam int SH_BIT        = 1;

  // Register byte offsets
  localparam logic [7:0]  OFS_PAGE_HIGH   = 8'h00;
  localparam logic [7:0]  OFS_PAGE_LOW    = 8'h04;
  localparam logic [7:0]  OFS_PAGE_ASSIST = 8'h08;
  localparam logic [7:0]  OFS_FAULT_ADDR  = 8'h0c;
  localparam logic [7:0]  OFS_CTRL        = 8'h10;
  localparam logic [7:0]  OFS_CODE        = 8'h14;
  localparam logic [7:0]  OFS_SAVED_PC    = 8'h18;
  localparam logic [7:0]  OFS_SAVED_STATE = 8'h1c;
  localparam logic [7:0]  OFS_SAVED_STACK = 8'h20;
  localparam logic [7:0]  OFS_STATE       = 8'h24;
  localparam logic [7:0]  OFS_VEC_BASE    = 8'h28;
  localparam logic [31:0] REG_RESET       = 32'h0000_0000;

  // Kind of data access
  typedef enum logic [2:0] {
    ACC_READ, ACC_WRITE, ACC_PURGE, ACC_WBACK, ACC_INVAL, ACC_ALLOC
  } acc_kind_t;

  // Fault cause after precedence
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_MULTI, CAUSE_MISS, CAUSE_PROT, CAUSE_IPW
  } cause_t;

  // Access request from the pipeline
  typedef struct packed {
    logic        valid;
    logic        ibuf_search;
    acc_kind_t   kind;
    logic [31:0] vaddr;
    logic [31:0] pc;
    logic        delay_slot;
    logic [31:0] branch_pc;
    logic [31:0] r15;
  } access_t;

  // Result back to the pipeline
  typedef struct packed {
    logic        done;
    logic        fault;
    logic [31:0] paddr;
    logic [31:0] vector;
  } result_t;
endpackage

// ===== hdl/dtlb_exc_unit.sv
// Data translation buffer lookup, fault detection and exception entry
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module dtlb_exc_unit (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [31:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire dtlb_exc_pkg::access_t acc_i,
  input  wire logic                  load_translation_entry_i,
  output dtlb_exc_pkg::result_t      res_o,
  output logic      [31:0]           cpu_state_word_o
);
  import dtlb_exc_pkg::*;

  // Byte lane merge for bus writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Page number compare mask from the size bits
  function automatic logic [21:0] page_mask(input logic sz1, input logic sz0);
    logic [21:0] m;
    m = 22'h3fffff;
    unique case ({sz1, sz0})
      2'b00: m = 22'h3fffff;
      2'b01: m = 22'h3ffffc;
      2'b10: m = 22'h3fffc0;
      2'b11: m = 22'h3ffc00;
    endcase
    return m;
  endfunction

  // Reads and writes as the access code sees them
  function automatic logic is_write(input acc_kind_t k);
    return (k == ACC_WRITE) || (k == ACC_INVAL) || (k == ACC_ALLOC);
  endfunction

  // Software visible registers
  logic [31:0] page_entry_high_r;       // Page number and space id
  logic [31:0] page_entry_low_r;        // Page attributes for loading
  logic [31:0] page_entry_assist_r;     // Assist bits for loading
  logic [31:0] fault_address_reg_r;     // Faulting address
  logic [31:0] translation_control_reg_r; // Replacement counter and boundary
  logic [31:0] exception_event_code_r;  // Last event code
  logic [31:0] saved_program_counter_r; // Return address
  logic [31:0] saved_status_reg_r;      // State word at entry
  logic [31:0] saved_stack_reg_r;       // Stack register at entry
  logic [31:0] cpu_state_word_r;        // Mode bits
  logic [31:0] vector_base_reg_r;       // Handler base

  // Translation entries
  logic [21:0]        e_page [ENTRIES];   // Virtual page numbers
  logic [7:0]         e_asid [ENTRIES];   // Space ids
  logic [31:0]        e_data [ENTRIES];   // Page attributes
  logic [3:0]         e_assist [ENTRIES]; // Assist bits
  logic [ENTRIES-1:0] e_valid_r;          // Valid flags

  // Bus registers
  logic        ack_r;  // Bus answer
  logic [31:0] dat_r;  // Read data
  result_t     res_r;  // Result to pipeline

  // Lookup wires
  logic [ENTRIES-1:0] match_vec;   // Entries matching the address
  logic               any_hit;     // At least one match
  logic               multi_hit;   // Two or more matches
  logic [IDX_W-1:0]   hit_idx;     // Lowest matching entry
  logic [31:0]        hit_data;    // Attributes of that entry
  logic [31:0]        amask;       // Address bits taken from the page
  logic [31:0]        paddr;       // Translated address
  logic               acc_wr;      // Access counts as a write
  logic               prot_bad;    // Access right forbids the access
  cause_t             cause;       // Fault after precedence
  logic               exc_take;    // Exception entry this cycle
  logic [31:0]        code_nxt;    // Event code to write
  logic [31:0]        vector_nxt;  // Branch target
  logic [IDX_W-1:0]   rcnt;        // Replacement counter
  logic               privileged;  // Privilege mode bit

  // Bus decode
  logic        bus_req;  // Request standing
  logic        bus_wr;   // Write commits at this edge
  logic        mapped;   // Upper address bits are clear
  logic [31:0] rd_mux;   // Selected read value

  // Compare each entry against the request address
  // per-entry match on page and space id
  for (genvar i = 0; i < ENTRIES; i++) begin : g_match
    assign match_vec[i] = e_valid_r[i]
      && (((e_page[i] ^ acc_i.vaddr[31:PAGE_NUM_LSB]) & page_mask(e_data[i][SZ1_BIT], e_data[i][SZ0_BIT])) == 22'h0)
      && (e_data[i][SH_BIT] || (e_asid[i] == page_entry_high_r[7:0]));
  end

  // more than one bit set means multiple hit
  assign any_hit   = |match_vec;
  assign multi_hit = |(match_vec & (match_vec - 1'b1));

  // Pick the lowest matching entry
  always_comb begin
    hit_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (match_vec[i]) begin
        hit_idx = IDX_W'(i);
      end
    end
  end

  assign hit_data   = e_data[hit_idx];
  assign amask      = {page_mask(hit_data[SZ1_BIT], hit_data[SZ0_BIT]), 10'h000};
  assign paddr      = ({3'b000, hit_data[PHYS_PAGE_MSB:PHYS_PAGE_LSB], 10'h000} & amask) | (acc_i.vaddr & ~amask);
  assign privileged = cpu_state_word_r[PRIV_MODE_POS];
  // cache operations sorted into read or write
  assign acc_wr     = is_write(acc_i.kind);
  // user access to privileged page or write to read-only page
  assign prot_bad   = (!privileged && !hit_data[RIGHTS_LSB+1]) || (acc_wr && !hit_data[RIGHTS_LSB]);
  assign rcnt       = translation_control_reg_r[RCNT_LSB +: IDX_W];

  // one cause, multiple hit first, then miss, violation, first write
  // an instruction-side search only reports multiple hit
  assign cause = multi_hit ? CAUSE_MULTI :
                 acc_i.ibuf_search ? CAUSE_NONE :
                 !any_hit ? CAUSE_MISS :
                 prot_bad ? CAUSE_PROT :
                 (acc_wr && !hit_data[D_BIT]) ? CAUSE_IPW : CAUSE_NONE;
  assign exc_take = acc_i.valid && (cause != CAUSE_NONE);

  // Event code per cause
  // multiple hit code
  assign code_nxt = (cause == CAUSE_MULTI) ? CODE_MULTI :
                    (cause == CAUSE_MISS)  ? (acc_wr ? CODE_MISS_WR : CODE_MISS_RD) :
                    (cause == CAUSE_PROT)  ? (acc_wr ? CODE_PROT_WR : CODE_PROT_RD) : CODE_IPW;

  // Branch target per cause
  // miss offset
  // violation and first write share one offset
  assign vector_nxt = (cause == CAUSE_MULTI) ? RESET_VECTOR :
                      (cause == CAUSE_MISS)  ? (vector_base_reg_r + OFF_MISS) :
                                               (vector_base_reg_r + OFF_PROT);

  // Bus decode
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr  = bus_req && wb_we_i && ack_r && mapped;
  assign mapped  = (wb_adr_i[31:8] == 24'h0);

  // Read selection, unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0;
    if (mapped) begin
      unique case (wb_adr_i[7:0])
        OFS_PAGE_HIGH:   rd_mux = page_entry_high_r;
        OFS_PAGE_LOW:    rd_mux = page_entry_low_r;
        OFS_PAGE_ASSIST: rd_mux = page_entry_assist_r;
        OFS_FAULT_ADDR:  rd_mux = fault_address_reg_r;
        OFS_CTRL:        rd_mux = translation_control_reg_r;
        OFS_CODE:        rd_mux = exception_event_code_r;
        OFS_SAVED_PC:    rd_mux = saved_program_counter_r;
        OFS_SAVED_STATE: rd_mux = saved_status_reg_r;
        OFS_SAVED_STACK: rd_mux = saved_stack_reg_r;
        OFS_STATE:       rd_mux = cpu_state_word_r;
        OFS_VEC_BASE:    rd_mux = vector_base_reg_r;
        default:  rd_mux = 32'h0;
      endcase
    end
  end

  // Bus answer one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= bus_req && !ack_r;
      if (bus_req && !ack_r) begin
        dat_r <= rd_mux;
      end
    end
  end

  // Registers only software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_entry_low_r          <= REG_RESET;
      page_entry_assist_r       <= REG_RESET;
      translation_control_reg_r <= REG_RESET;
      vector_base_reg_r         <= REG_RESET;
    end else if (bus_wr) begin
      if (wb_adr_i[7:0] == OFS_PAGE_LOW) begin
        page_entry_low_r <= merge(page_entry_low_r, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i[7:0] == OFS_PAGE_ASSIST) begin
        page_entry_assist_r <= merge(page_entry_assist_r, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i[7:0] == OFS_CTRL) begin
        translation_control_reg_r <= merge(translation_control_reg_r, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i[7:0] == OFS_VEC_BASE) begin
        vector_base_reg_r <= merge(vector_base_reg_r, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Registers shared by software and exception entry, entry wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_entry_high_r       <= REG_RESET;
      fault_address_reg_r     <= REG_RESET;
      exception_event_code_r  <= REG_RESET;
      saved_program_counter_r <= REG_RESET;
      saved_status_reg_r      <= REG_RESET;
      saved_stack_reg_r       <= REG_RESET;
      cpu_state_word_r        <= STATE_RESET;
    end else if (exc_take) begin
      // fault address and code on every fault
      fault_address_reg_r    <= acc_i.vaddr;
      exception_event_code_r <= code_nxt;
      if (cause == CAUSE_MULTI) begin
        // state word returns to its reset value
        cpu_state_word_r <= STATE_RESET;
      end else begin
        // page number into page entry high, space id kept
        page_entry_high_r[31:PAGE_NUM_LSB] <= acc_i.vaddr[31:PAGE_NUM_LSB];
        // delay slot faults return to the branch
        saved_program_counter_r <= acc_i.delay_slot ? acc_i.branch_pc : acc_i.pc;
        // save state word and stack register
        saved_status_reg_r <= cpu_state_word_r;
        saved_stack_reg_r  <= acc_i.r15;
        cpu_state_word_r[PRIV_MODE_POS] <= 1'b1;
        cpu_state_word_r[EXC_BLOCK_POS] <= 1'b1;
        cpu_state_word_r[BANK_SEL_POS]  <= 1'b1;
      end
    end else if (bus_wr) begin
      unique case (wb_adr_i[7:0])
        OFS_PAGE_HIGH:   page_entry_high_r       <= merge(page_entry_high_r, wb_dat_i, wb_sel_i);
        OFS_FAULT_ADDR:  fault_address_reg_r     <= merge(fault_address_reg_r, wb_dat_i, wb_sel_i);
        OFS_CODE:        exception_event_code_r  <= merge(exception_event_code_r, wb_dat_i, wb_sel_i);
        OFS_SAVED_PC:    saved_program_counter_r <= merge(saved_program_counter_r, wb_dat_i, wb_sel_i);
        OFS_SAVED_STATE: saved_status_reg_r      <= merge(saved_status_reg_r, wb_dat_i, wb_sel_i);
        OFS_SAVED_STACK: saved_stack_reg_r       <= merge(saved_stack_reg_r, wb_dat_i, wb_sel_i);
        OFS_STATE:       cpu_state_word_r        <= merge(cpu_state_word_r, wb_dat_i, wb_sel_i);
        default:  cpu_state_word_r        <= cpu_state_word_r;
      endcase
    end
  end

  // Entry valid flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      e_valid_r <= '0;
    end else if (load_translation_entry_i) begin
      // valid flag from page entry low
      e_valid_r[rcnt] <= page_entry_low_r[V_BIT];
    end
  end

  // Entry contents, no reset needed behind the valid flags
  always_ff @(posedge clk_i) begin
    if (load_translation_entry_i) begin
      // copy the three page entry registers
      // the slot is the replacement counter software set
      e_page[rcnt]   <= page_entry_high_r[31:PAGE_NUM_LSB];
      e_asid[rcnt]   <= page_entry_high_r[7:0];
      e_data[rcnt]   <= page_entry_low_r;
      e_assist[rcnt] <= page_entry_assist_r[3:0];
    end
  end

  // Result to the pipeline one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_r <= '0;
    end else begin
      res_r.done   <= acc_i.valid;
      res_r.fault  <= exc_take;
      res_r.paddr  <= (acc_i.valid && !exc_take) ? paddr : 32'h0;
      res_r.vector <= exc_take ? vector_nxt : 32'h0;
    end
  end

  assign wb_ack_o         = ack_r;
  assign wb_dat_o         = dat_r;
  assign res_o            = res_r;
  assign cpu_state_word_o = cpu_state_word_r;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_fault(cause_t c);
    acc_i.valid && (cause == c);
  endsequence

  sequence s_entry;
    acc_i.valid && (cause inside {CAUSE_MISS, CAUSE_PROT, CAUSE_IPW});
  endsequence

  a_multi_entry: assert property (s_fault(CAUSE_MULTI) |=>
    (exception_event_code_r == CODE_MULTI) && (res_o.vector == RESET_VECTOR) && (cpu_state_word_r == STATE_RESET))
    else $error("multiple hit entry wrong");
  a_multi_count: assert property ((acc_i.valid && ($countones(match_vec) > 1)) |=> res_o.fault)
    else $error("multiple hit not reported");
  a_miss_code: assert property (s_fault(CAUSE_MISS) |=>
    exception_event_code_r == ($past(acc_wr) ? CODE_MISS_WR : CODE_MISS_RD))
    else $error("miss code wrong");
  a_miss_vector: assert property (s_fault(CAUSE_MISS) |=>
    res_o.vector == $past(vector_base_reg_r) + OFF_MISS)
    else $error("miss vector wrong");
  a_prot_code: assert property (s_fault(CAUSE_PROT) |=>
    (exception_event_code_r == ($past(acc_wr) ? CODE_PROT_WR : CODE_PROT_RD))
    && (res_o.vector == $past(vector_base_reg_r) + OFF_PROT))
    else $error("violation entry wrong");
  a_ipw_code: assert property (s_fault(CAUSE_IPW) |=>
    (exception_event_code_r == CODE_IPW) && (res_o.vector == $past(vector_base_reg_r) + OFF_PROT))
    else $error("first write entry wrong");
  a_fault_regs: assert property (s_entry |=>
    (fault_address_reg_r == $past(acc_i.vaddr))
    && (page_entry_high_r[31:PAGE_NUM_LSB] == $past(acc_i.vaddr[31:PAGE_NUM_LSB])))
    else $error("fault address not loaded");
  a_saved_pc: assert property (s_entry |=>
    saved_program_counter_r == ($past(acc_i.delay_slot) ? $past(acc_i.branch_pc) : $past(acc_i.pc)))
    else $error("saved counter wrong");
  a_state_save: assert property (s_entry |=>
    (saved_status_reg_r == $past(cpu_state_word_r)) && (saved_stack_reg_r == $past(acc_i.r15)))
    else $error("state not saved");
  a_mode_bits: assert property (s_entry |=>
    cpu_state_word_r[PRIV_MODE_POS] && cpu_state_word_r[EXC_BLOCK_POS] && cpu_state_word_r[BANK_SEL_POS])
    else $error("mode bits not set");
  a_load_entry: assert property (load_translation_entry_i |=>
    (e_valid_r[$past(rcnt)] == $past(page_entry_low_r[V_BIT])) && (e_data[$past(rcnt)] == $past(page_entry_low_r)))
    else $error("entry not loaded");
  a_clean_miss: assert property ((acc_i.valid && !acc_i.ibuf_search && !any_hit) |=>
    res_o.fault && (res_o.paddr == 32'h0))
    else $error("miss not reported");
endmodule

// ===== verification/core_model.sv
// Pipeline model that issues data accesses and load pulses
`timescale 1ns/1ps
module core_model (
  input  wire logic                  clk_i,
  input  wire dtlb_exc_pkg::result_t res_i,
  output dtlb_exc_pkg::access_t      acc_o,
  output logic                       load_translation_entry_o
);
  import dtlb_exc_pkg::*;

  result_t last_res; // Result of the latest access

  // Quiet pipeline at time zero
  initial begin
    acc_o                    = '0;
    load_translation_entry_o = 1'b0;
  end

  // One access; fields scrambled once it is taken
  task automatic issue(input access_t a);
    access_t junk;
    junk       = ~a;
    junk.valid = 1'b0;
    @(posedge clk_i);
    acc_o <= a;
    @(posedge clk_i);
    acc_o <= junk;
    // Result is settled half a cycle after the taking edge
    @(negedge clk_i);
    last_res = res_i;
  endtask

  task automatic load();
    @(posedge clk_i);
    load_translation_entry_o <= 1'b1;
    @(posedge clk_i);
    load_translation_entry_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench of the data translation fault unit
`timescale 1ns/1ps
module tb;
  import dtlb_exc_pkg::*;

  logic        clk_i  = 1'b0; // Core clock
  logic        rst_i  = 1'b1; // Synchronous reset
  logic        wb_cyc = 1'b0; // Bus cycle
  logic        wb_stb = 1'b0; // Bus strobe
  logic        wb_we  = 1'b0; // Bus direction
  logic [31:0] wb_adr = '0;   // Bus address
  logic [31:0] wb_dat = '0;   // Bus write data
  logic [3:0]  wb_sel = '0;   // Byte enables
  logic [31:0] wb_rd;         // Bus read data
  logic        wb_ack;        // Bus answer
  logic        load_pulse;    // Load pulse
  logic [31:0] state_word;    // State word output
  logic [31:0] q;             // Last read value
  access_t     acc;           // Access request
  result_t     res;           // Access result
  int          n_fail = 0;
  int          num_checks = 0;

  // Clock generation
  always #12.5 clk_i = ~clk_i;

  dtlb_exc_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .acc_i(acc), .load_translation_entry_i(load_pulse), .res_o(res),
    .cpu_state_word_o(state_word));

  core_model core (.clk_i(clk_i), .res_i(res), .acc_o(acc), .load_translation_entry_o(load_pulse));

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Classic single bus cycle, held until ack
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hf;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // Register read by offset
  task automatic rd(input logic [7:0] o);
    wb(1'b0, {24'h0, o}, 32'h0);
  endtask

  // Expected event code per cause and kind
  function automatic logic [31:0] exp_code(input cause_t c, input acc_kind_t k);
    logic wr;
    wr = (k == ACC_WRITE || k == ACC_INVAL || k == ACC_ALLOC);
    case (c)
      CAUSE_MULTI: return CODE_MULTI;
      CAUSE_MISS:  return wr ? CODE_MISS_WR : CODE_MISS_RD;
      CAUSE_PROT:  return wr ? CODE_PROT_WR : CODE_PROT_RD;
      default:     return CODE_IPW;
    endcase
  endfunction

  task automatic load_entry(input logic [5:0] idx, input logic [31:0] va, input logic [1:0] pr, input logic d);
    wb(1'b1, {24'h0, OFS_PAGE_HIGH}, {va[31:10], 10'h0});
    wb(1'b1, {24'h0, OFS_PAGE_LOW}, {3'h0, 19'($urandom), 2'b01, 1'b0, pr, 2'b00, d, 2'b00});
    wb(1'b1, {24'h0, OFS_CTRL}, {16'h0, idx, 10'h0});
    core.load();
  endtask

  // One access and a check of the whole exception entry
  task automatic probe(input cause_t c, input acc_kind_t k, input logic [31:0] va, input logic it, input logic md);
    access_t     a;
    result_t     r;
    logic [31:0] sw0;
    logic [31:0] vec_base;
    sw0 = ($urandom & 32'h8fff_ffff) | {1'b0, md, 30'h0};
    vec_base = $urandom & 32'hffff_f000;
    wb(1'b1, {24'h0, OFS_STATE}, sw0);
    wb(1'b1, {24'h0, OFS_VEC_BASE}, vec_base);
    a = {1'b1, it, k, va, $urandom, 1'($urandom), $urandom, $urandom};
    core.issue(a);
    r = core.last_res;
    chk("done", {31'h0, r.done}, 32'h1);
    chk("fault", {31'h0, r.fault}, {31'h0, c != CAUSE_NONE});
    // No exception: translation goes through
    if (c == CAUSE_NONE) begin
      chk("no vector", r.vector, 32'h0);
      chk("paddr", {22'h0, r.paddr[9:0]}, {22'h0, va[9:0]});
      // Page frame comes from the entry loaded last
      if (!it) begin
        rd(OFS_PAGE_LOW);
        chk("paddr frame", r.paddr, {3'h0, q[PHYS_PAGE_MSB:PHYS_PAGE_LSB], va[9:0]});
      end
      return;
    end
    chk("vector", r.vector, c == CAUSE_MULTI ? RESET_VECTOR : vec_base + (c == CAUSE_MISS ? OFF_MISS : OFF_PROT));
    chk("state word", state_word, c == CAUSE_MULTI ? STATE_RESET : sw0 | 32'h7000_0000);
    rd(OFS_FAULT_ADDR);
    chk("fault address", q, va);
    rd(OFS_CODE);
    chk("event code", q, exp_code(c, k));
    // Reset-like entry saves nothing else
    if (c == CAUSE_MULTI) return;
    rd(OFS_PAGE_HIGH);
    chk("page high", {q[31:10], 10'h0}, {va[31:10], 10'h0});
    rd(OFS_SAVED_PC);
    chk("saved pc", q, a.delay_slot ? a.branch_pc : a.pc);
    rd(OFS_SAVED_STATE);
    chk("saved state", q, sw0);
    rd(OFS_SAVED_STACK);
    chk("saved stack", q, a.r15);
  endtask

  // Main sequence
  initial begin
    logic [31:0] pa;
    logic [31:0] pb;
    void'($urandom(54452));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Refused write, then reset values and an unlisted offset
    wb(1'b1, 32'h0000_0104, 32'hffff_ffff);
    for (int i = 0; i < 12; i++) begin
      wb(1'b0, 32'(i * 4), 32'h0);
      chk("reset value", q, i == 9 ? STATE_RESET : REG_RESET);
    end
    // Misses of every access kind on an empty buffer
    for (int k = 0; k < 6; k++) begin
      probe(CAUSE_MISS, acc_kind_t'(k), {4'h4, 28'($urandom)}, 1'b0, 1'b1);
    end
    probe(CAUSE_NONE, ACC_READ, {4'h5, 28'($urandom)}, 1'b1, 1'b1);
    pa = {4'h1, 28'($urandom)};
    pb = {4'h2, 28'($urandom)};
    // Clean writable page: read hits, writes fault
    load_entry(6'd0, pa, 2'b01, 1'b0);
    probe(CAUSE_NONE, ACC_READ, pa, 1'b0, 1'b1);
    probe(CAUSE_IPW, ACC_WRITE, pa, 1'b0, 1'b1);
    probe(CAUSE_IPW, ACC_ALLOC, pa, 1'b0, 1'b1);
    // Read-only privileged page: violation wins over first write
    load_entry(6'd63, pb, 2'b00, 1'b0);
    probe(CAUSE_PROT, ACC_WRITE, pb, 1'b0, 1'b1);
    probe(CAUSE_PROT, ACC_PURGE, pb, 1'b0, 1'b0);
    // Second entry on the same page: multiple hit
    load_entry(6'd2, pb, 2'b11, 1'b1);
    probe(CAUSE_MULTI, ACC_WRITE, pb, 1'b0, 1'b1);
    probe(CAUSE_MULTI, ACC_READ, pb, 1'b1, 1'b0);
    // Dirty user page accepts a user write
    load_entry(6'd3, {4'h3, 28'($urandom)}, 2'b11, 1'b1);
    rd(OFS_PAGE_HIGH);
    probe(CAUSE_NONE, ACC_WRITE, {q[31:10], 10'($urandom)}, 1'b0, 1'b0);
    summarize();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    summarize();
  end
endmodule
